/* core/pel_event_logic.sv */
// PWM logic-function routing, event outputs and pseudorandom register.
// Generator, protection-input and logic-result signals arrive from other clock
// domains and pass a two-flop synchroniser; registers sit on Avalon-MM.
`timescale 1ns/1ps

module pel_event_logic
   import pel_pkg::*;
#(
   parameter logic [NUM_GEN-1:0] GEN_PRESENT = 4'hF
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Generator-side signals, one bit per generator
   input wire logic [NUM_GEN-1:0] gen_trigger_in,
   input wire logic [NUM_GEN-1:0] gen_raw_out_in,
   input wire logic [NUM_GEN-1:0] pci_sync_in,
   input wire logic [NUM_GEN-1:0] pci_feedfwd_in,
   input wire logic [NUM_GEN-1:0] pci_curlim_in,
   input wire logic [NUM_GEN-1:0] pci_fault_in,
   input wire logic [NUM_GEN-1:0] half_period_signal,
   input wire logic [NUM_GEN-1:0] output_steering_signal,
   input wire logic [NUM_GEN-1:0] adc_trig1_in,
   input wire logic [NUM_GEN-1:0] adc_trig2_in,
   input wire logic [NUM_GEN-1:0] center_mode_in,
   input wire logic [NUM_GEN-1:0] push_pull_mode_in,
   // Logic function results and generator pin drive
   input wire logic [NUM_INST-1:0] logic_result_in,
   input wire logic [NUM_GEN-1:0] gen_high_in,
   input wire logic [NUM_GEN-1:0] gen_low_in,
   // Pins
   output logic [NUM_GEN-1:0] high_side_pin,
   output logic [NUM_GEN-1:0] low_side_pin,
   output logic [NUM_INST-1:0] event_output_pin,
   output logic [NUM_INST-1:0] event_pin_oe,
   output logic [NUM_INST-1:0] event_internal
);

   // -----------------------------------------------------------------
   // Input synchroniser
   // -----------------------------------------------------------------
   logic [SYNC_W-1:0] sync_a_ff;
   logic [SYNC_W-1:0] sync_b_ff;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_a_ff <= '0;
         sync_b_ff <= '0;
      end
      else
      begin
         sync_a_ff <= {gen_trigger_in, gen_raw_out_in, pci_sync_in, pci_feedfwd_in, pci_curlim_in,
                       pci_fault_in, half_period_signal, output_steering_signal, adc_trig1_in,
                       adc_trig2_in, center_mode_in, push_pull_mode_in, logic_result_in,
                       gen_high_in, gen_low_in};
         sync_b_ff <= sync_a_ff;
      end
   end

   // Only these masked copies are read; sync_a_ff feeds nothing but sync_b_ff
   logic [NUM_GEN-1:0] s_trig;
   logic [NUM_GEN-1:0] s_gout;
   logic [NUM_GEN-1:0] s_psync;
   logic [NUM_GEN-1:0] s_pff;
   logic [NUM_GEN-1:0] s_pcl;
   logic [NUM_GEN-1:0] s_pfault;
   logic [NUM_GEN-1:0] s_half;
   logic [NUM_GEN-1:0] s_output_steering_signal;
   logic [NUM_GEN-1:0] s_adc1;
   logic [NUM_GEN-1:0] s_adc2;
   logic [NUM_GEN-1:0] s_center;
   logic [NUM_GEN-1:0] s_pushpull;
   logic [NUM_GEN-1:0] s_high;
   logic [NUM_GEN-1:0] s_low;
   logic [NUM_INST-1:0] s_result;

   // Absent generators contribute zero everywhere
   assign {s_trig, s_gout, s_psync, s_pff, s_pcl, s_pfault, s_half, s_output_steering_signal, s_adc1, s_adc2,
           s_center, s_pushpull, s_result, s_high, s_low} =
          sync_b_ff & {{12{GEN_PRESENT}}, {NUM_INST{1'b1}}, GEN_PRESENT, GEN_PRESENT}; // [R02]

   // -----------------------------------------------------------------
   // Register bus
   // -----------------------------------------------------------------
   pel_bus_state_t bus_state_ff;
   logic [15:0] logic_ctrl_ff [NUM_INST];
   logic [15:0] event_ctrl_ff [NUM_INST];
   logic [14:0] prng_ff;
   logic [15:0] rd_word;
   logic wr_fire;
   logic [15:0] lane_mask;

   // Waitrequest stays high until one cycle after the request is seen,
   // so every access completes on the second edge.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         bus_state_ff <= BUS_IDLE;
      else
      begin
         case (bus_state_ff)
            BUS_IDLE: bus_state_ff <= (avs_read || avs_write) ? BUS_ACK : BUS_IDLE;
            BUS_ACK: bus_state_ff <= BUS_IDLE;
            default: bus_state_ff <= BUS_IDLE;
         endcase
      end
   end

   assign wr_fire = (bus_state_ff == BUS_ACK) && avs_write;
   assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   // -----------------------------------------------------------------
   // Read path; reads have no side effects
   // -----------------------------------------------------------------

   always_comb
   begin
      rd_word = 16'h0000;
      if (avs_address >= OFS_LOGIC_CTRL0 && avs_address < OFS_EVENT_CTRL0)
         rd_word = logic_ctrl_ff[3'(avs_address - OFS_LOGIC_CTRL0)];
      else if (avs_address >= OFS_EVENT_CTRL0 && avs_address < OFS_PRNG)
         rd_word = event_ctrl_ff[3'(avs_address - OFS_EVENT_CTRL0)];
      else if (avs_address == OFS_PRNG)
         rd_word = {1'b0, prng_ff}; // [R17]
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end
      else
      begin
         avs_waitrequest <= !((bus_state_ff == BUS_IDLE) && (avs_read || avs_write));
         if ((bus_state_ff == BUS_IDLE) && avs_read)
            avs_readdata <= {16'h0000, rd_word};
      end
   end

   // -----------------------------------------------------------------
   // Pseudorandom register
   // -----------------------------------------------------------------
   logic prng_fb;

   // x^15 + x^14 + 1; a zero state feeds a one so it cannot stick
   assign prng_fb = (prng_ff[14] ^ prng_ff[13]) | (prng_ff == 15'h0000); // [R18]

   // A bus write wins over the shift in the same cycle
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         prng_ff <= PRNG_RESET;
      else if (wr_fire && avs_address == OFS_PRNG)
         prng_ff <= (prng_ff & ~lane_mask[14:0]) | (avs_writedata[14:0] & lane_mask[14:0]);
      else
         prng_ff <= {prng_ff[13:0], prng_fb}; // [R18]
   end

   // -----------------------------------------------------------------
   // Logic function routing onto pin pairs
   // -----------------------------------------------------------------
   logic [NUM_GEN-1:0] lf_high [NUM_INST];
   logic [NUM_GEN-1:0] lf_low [NUM_INST];
   logic [NUM_GEN-1:0] hit_high;
   logic [NUM_GEN-1:0] hit_low;
   logic [NUM_GEN-1:0] val_high;
   logic [NUM_GEN-1:0] val_low;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_INST; gi++)
      begin : g_inst
         logic [2:0] dest;
         logic [NUM_GEN-1:0] onehot;

         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
               logic_ctrl_ff[gi] <= CTRL_RESET;
            else if (wr_fire && avs_address == 4'(OFS_LOGIC_CTRL0 + gi))
               logic_ctrl_ff[gi] <= (logic_ctrl_ff[gi] & ~lane_mask)
                                    | (avs_writedata[15:0] & lane_mask & LOGIC_CTRL_MASK);
         end

         assign dest = logic_ctrl_ff[gi][LOGIC_DEST_LSB +: 3];
         // Zero and reserved codes select nothing
         assign onehot = (dest != DEST_OFF && dest <= DEST_PAIR4)
                         ? 4'(4'h1 << dest) : 4'h0; // [R01]
         assign lf_high[gi] = ((gi % 2) == 0) ? onehot : 4'h0; // [R03]
         assign lf_low[gi] = ((gi % 2) == 1) ? onehot : 4'h0; // [R03]

         // -----------------------------------------------------------
         // Event output path
         // -----------------------------------------------------------
         logic [15:0] ctl;
         logic [1:0] gsel;
         logic gen_ok;
         logic src;
         logic src_ff;
         logic prev_ff;
         logic str_ff;
         logic s1_ff;
         logic s2_ff;
         logic s3_ff;
         logic p_ff;
         logic p2_ff;
         logic lvl_ff;
         logic [2:0] cnt_ff;

         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
               event_ctrl_ff[gi] <= CTRL_RESET;
            else if (wr_fire && avs_address == 4'(OFS_EVENT_CTRL0 + gi))
               event_ctrl_ff[gi] <= (event_ctrl_ff[gi] & ~lane_mask)
                                    | (avs_writedata[15:0] & lane_mask & EVENT_CTRL_MASK);
         end

         assign ctl = event_ctrl_ff[gi];
         assign gsel = ctl[EV_GEN_LSB +: 2];
         assign gen_ok = (ctl[EV_GEN_LSB +: 3] <= GEN_LAST) && GEN_PRESENT[gsel]; // [R15] [R16]

         // -----------------------------------------------------------
         // Event source selection
         // -----------------------------------------------------------

         always_comb
         begin
            src = 1'b0;
            if (gen_ok) // [R16]
            begin
               case (ctl[EV_SEL_LSB +: 4])
                  SEL_GEN_TRIG: src = s_trig[gsel]; // [R10]
                  SEL_GEN_OUT: src = s_gout[gsel]; // [R10] [R13]
                  SEL_PCI_SYNC: src = s_psync[gsel]; // [R11]
                  SEL_PCI_FF: src = s_pff[gsel]; // [R11]
                  SEL_PCI_CL: src = s_pcl[gsel]; // [R11]
                  SEL_PCI_FAULT: src = s_pfault[gsel]; // [R11]
                  SEL_HALF: src = s_half[gsel] & s_center[gsel]; // [R12] [R14]
                  SEL_OUTPUT_STEERING_SIGNAL: src = s_output_steering_signal[gsel] & s_pushpull[gsel]; // [R12] [R14]
                  SEL_ADC1: src = s_adc1[gsel]; // [R10]
                  SEL_ADC2: src = s_adc2[gsel]; // [R10]
                  default: src = 1'b0;
               endcase
            end
         end

         // -----------------------------------------------------------
         // Pulse stretching
         // -----------------------------------------------------------
         // Stretch counted on the peripheral clock, never a generator clock
         // A new rising edge reloads the count, so bursts merge
         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               src_ff <= 1'b0;
               prev_ff <= 1'b0;
               cnt_ff <= 3'h0;
               str_ff <= 1'b0;
            end
            else
            begin
               src_ff <= src;
               prev_ff <= src_ff;
               if (!ctl[EV_STRD_BIT] && src_ff && !prev_ff)
                  cnt_ff <= STRETCH_LOAD; // [R06] [R07]
               else if (cnt_ff != 3'h0)
                  cnt_ff <= cnt_ff - 3'h1; // [R07]
               str_ff <= ctl[EV_STRD_BIT] ? src_ff : (src_ff | (cnt_ff != 3'h0)); // [R06]
            end
         end

         // -----------------------------------------------------------
         // Resynchronisation
         // -----------------------------------------------------------
         // System-clock resynchronisation stage, bypassed when sync is off
         // Source edges fewer than three cycles apart merge into one pulse
         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               s1_ff <= 1'b0;
               s2_ff <= 1'b0;
               s3_ff <= 1'b0;
               p_ff <= 1'b0;
               p2_ff <= 1'b0;
               lvl_ff <= 1'b0;
            end
            else
            begin
               s1_ff <= str_ff;
               s2_ff <= s1_ff;
               s3_ff <= s2_ff;
               p_ff <= s2_ff & !s3_ff;
               p2_ff <= p_ff;
               if (ctl[EV_SYNC_BIT]) // [R08]
                  lvl_ff <= ctl[EV_STRD_BIT] ? (p_ff | p2_ff) : s2_ff; // [R09]
               else
                  lvl_ff <= str_ff; // [R08]
            end
         end

         // -----------------------------------------------------------
         // Event pin drivers
         // -----------------------------------------------------------
         // Pin drivers; a disabled pin rests at its inactive level
         // Enable and level change on one edge, so enabling never glitches
         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               event_internal[gi] <= 1'b0;
               event_output_pin[gi] <= 1'b0;
               event_pin_oe[gi] <= 1'b0;
            end
            else
            begin
               event_internal[gi] <= lvl_ff ^ ctl[EV_POL_BIT]; // [R05]
               event_output_pin[gi] <= ctl[EV_PIN_EN_BIT] ? (lvl_ff ^ ctl[EV_POL_BIT])
                                                          : ctl[EV_POL_BIT]; // [R04] [R05]
               event_pin_oe[gi] <= ctl[EV_PIN_EN_BIT]; // [R04]
            end
         end
      end
   endgenerate

   // -----------------------------------------------------------------
   // Pin pair outputs
   // -----------------------------------------------------------------
   // Several instances on one pin are ORed together
   always_comb
   begin
      hit_high = 4'h0;
      hit_low = 4'h0;
      val_high = 4'h0;
      val_low = 4'h0;
      for (int i = 0; i < NUM_INST; i++)
      begin
         hit_high = hit_high | lf_high[i];
         hit_low = hit_low | lf_low[i];
         val_high = val_high | (lf_high[i] & {NUM_GEN{s_result[i]}});
         val_low = val_low | (lf_low[i] & {NUM_GEN{s_result[i]}});
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         high_side_pin <= 4'h0;
         low_side_pin <= 4'h0;
      end
      else
      begin
         high_side_pin <= (s_high & ~hit_high) | val_high; // [R01] [R03]
         low_side_pin <= (s_low & ~hit_low) | val_low; // [R01] [R03]
      end
   end

endmodule : pel_event_logic

/* core/pel_pkg.sv */
// Constants shared by the PWM event and output logic block.
// Assumes a single 50 MHz core clock that also serves as peripheral and system clock.
// Function
// [R01] Destination code routes logic result to pair
// [R02] Signals of absent generators read as zero
// [R03] A, C, E drive high; B, D, F low
// [R04] Pin enable puts event on its pin
// [R05] Polarity bit set makes event active low
// [R06] Stretch events to eight cycles unless disabled
// [R07] Stretch counter runs on peripheral clock
// [R08] Sync bit resynchronises event to system clock
// [R09] Sync without stretch gives two-cycle pulse
// [R10] Source codes: trigger, generator output, ADC triggers
// [R11] Codes 2-5 pick protection-input active signals
// [R12] Steering needs push-pull, half-period needs center-aligned
// [R13] Generator output tapped before mode and override
// [R14] Steering and half-period taken in generator domain
// [R15] Generator select 0-3 picks generator one-four
// [R16] Absent or reserved generator yields no event
// [R17] Pseudorandom read gives 15 bits, bit15 zero
// [R18] Maximal 15-bit feedback, advances, never locks up
package pel_pkg;

   // -----------------------------------------------------------------
   // Sizes
   // -----------------------------------------------------------------
   localparam int NUM_GEN = 4;
   localparam int NUM_INST = 6;
   localparam int ADDR_W = 4;
   localparam int SYNC_W = 12 * NUM_GEN + NUM_INST + 2 * NUM_GEN;

   // -----------------------------------------------------------------
   // Register word offsets
   // -----------------------------------------------------------------
   localparam logic [3:0] OFS_LOGIC_CTRL0 = 4'h0;
   localparam logic [3:0] OFS_EVENT_CTRL0 = 4'h6;
   localparam logic [3:0] OFS_PRNG = 4'hC;

   // -----------------------------------------------------------------
   // Field positions, masks and reset values
   // -----------------------------------------------------------------
   localparam logic [15:0] LOGIC_CTRL_MASK = 16'hFFF7;
   localparam logic [15:0] EVENT_CTRL_MASK = 16'hF0F7;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [14:0] PRNG_RESET = 15'h0000;
   localparam int EV_PIN_EN_BIT = 15;
   localparam int EV_POL_BIT = 14;
   localparam int EV_STRD_BIT = 13;
   localparam int EV_SYNC_BIT = 12;
   localparam int EV_SEL_LSB = 4;
   localparam int EV_GEN_LSB = 0;
   localparam int LOGIC_DEST_LSB = 0;

   // -----------------------------------------------------------------
   // Codes
   // -----------------------------------------------------------------
   localparam logic [2:0] DEST_OFF = 3'h0;
   localparam logic [2:0] DEST_PAIR4 = 3'h3;
   localparam logic [3:0] SEL_GEN_TRIG = 4'h0;
   localparam logic [3:0] SEL_GEN_OUT = 4'h1;
   localparam logic [3:0] SEL_PCI_SYNC = 4'h2;
   localparam logic [3:0] SEL_PCI_FF = 4'h3;
   localparam logic [3:0] SEL_PCI_CL = 4'h4;
   localparam logic [3:0] SEL_PCI_FAULT = 4'h5;
   localparam logic [3:0] SEL_HALF = 4'h6;
   localparam logic [3:0] SEL_OUTPUT_STEERING_SIGNAL = 4'h7;
   localparam logic [3:0] SEL_ADC1 = 4'h8;
   localparam logic [3:0] SEL_ADC2 = 4'h9;
   localparam logic [2:0] GEN_LAST = 3'h3;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int STRETCH_PERIODS = 8;
   localparam logic [2:0] STRETCH_LOAD = 3'(STRETCH_PERIODS - 1);

   typedef enum logic [1:0] {BUS_IDLE, BUS_ACK} pel_bus_state_t;

endpackage : pel_pkg

/* sim/pel_event_logic_asserts.sv */
// Port checker for the PWM event and output logic.
// Assumes binding onto pel_event_logic with its default parameters.
`timescale 1ns/1ps

module pel_event_logic_chk
   import pel_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register bus
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Pins
   input wire logic [NUM_GEN-1:0] gen_high_in,
   input wire logic [NUM_GEN-1:0] gen_low_in,
   input wire logic [NUM_GEN-1:0] high_side_pin,
   input wire logic [NUM_GEN-1:0] low_side_pin,
   input wire logic [NUM_INST-1:0] event_output_pin,
   input wire logic [NUM_INST-1:0] event_pin_oe,
   input wire logic [NUM_INST-1:0] event_internal
);
   // ----
   // Relations
   // ----
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_answer;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer one cycle after take");
   property p_wait_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
   property p_rd_upper;
      avs_readdata[31:16] == 16'h0000;
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper read data not zero");
   property p_prng15;
      avs_read && avs_address == OFS_PRNG && !avs_waitrequest |-> !avs_readdata[15];
   endproperty
   a_prng15: assert property (p_prng15) else $error("pseudorandom bit 15 set");
   property p_unmapped;
      avs_read && avs_address > OFS_PRNG && !avs_waitrequest |-> avs_readdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_rd_stable;
      !$past(avs_read) |-> $stable(avs_readdata);
   endproperty
   a_rd_stable: assert property (p_rd_stable) else $error("read data moved without read");
   // Pair 1 is never a logic destination, so it always follows the generator
   property p_pair1_hi;
      high_side_pin[0] == $past(gen_high_in[0], 3);
   endproperty
   a_pair1_hi: assert property (p_pair1_hi) else $error("pair 1 high pin wrong");
   property p_pair1_lo;
      low_side_pin[0] == $past(gen_low_in[0], 3);
   endproperty
   a_pair1_lo: assert property (p_pair1_lo) else $error("pair 1 low pin wrong");
   property p_oe;
      (event_pin_oe & $past(event_pin_oe) & (event_output_pin ^ event_internal)) == 6'h00;
   endproperty
   a_oe: assert property (p_oe) else $error("enabled pin differs from event");

endmodule : pel_event_logic_chk

bind pel_event_logic pel_event_logic_chk i_chk (.*);

/* sim/pel_event_logic_tb.sv */
// Bench for pel_event_logic: registers, pin routing, event sources.
// Assumes the far-side model and the bound port checker.
`timescale 1ns/1ps

module pel_event_logic_tb
   import pel_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [3:0] gen_trigger_in, gen_raw_out_in, pci_sync_in, pci_feedfwd_in, pci_curlim_in;
   logic [3:0] pci_fault_in, half_period_signal, output_steering_signal, adc_trig1_in;
   logic [3:0] adc_trig2_in, center_mode_in, push_pull_mode_in, high_side_pin, low_side_pin;
   logic [5:0] logic_result_in = 6'h00;
   logic [3:0] gen_high_in = 4'h0;
   logic [3:0] gen_low_in = 4'h0;
   logic [5:0] event_output_pin, event_pin_oe, event_internal;
   logic go = 1'b0;
   logic [3:0] kind = 4'h0;
   logic [2:0] gen = 3'h0;
   logic [7:0] width = 8'h00;
   logic mode_off = 1'b0;
   logic [31:0] rd, rd2;
   int cnt;
   int failures = 0;
   int comparisons = 0;

   pel_event_logic i_dut (.*);
   pel_gen_model i_gen (.*);

   initial forever #10 core_clk = ~core_clk;

   // ----
   // Shared tasks
   // ----
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Holds the request until waitrequest is sampled low
   task automatic xfer(input logic [3:0] a, input logic wr, input logic [15:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0 && n < 50)
      begin
         @(posedge core_clk);
         n++;
      end
      if (n == 50)
         failures++;
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask : xfer

   task automatic report_and_stop();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   // ----
   // Scenarios
   // ----
   task automatic t_regs();
      logic [3:0] adr [3] = '{OFS_LOGIC_CTRL0, OFS_EVENT_CTRL0, 4'hE};
      logic [15:0] msk [3] = '{LOGIC_CTRL_MASK, EVENT_CTRL_MASK, 16'h0000};
      for (int i = 0; i < 3; i++)
      begin
         xfer(adr[i], 1'b0, 16'h0000);
         check(rd, 32'h0);
         xfer(adr[i], 1'b1, 16'hFFFF);
         xfer(adr[i], 1'b0, 16'h0000);
         check(rd, {16'h0000, msk[i]});
         xfer(adr[i], 1'b1, 16'h0000);
      end
      $display("register test done");
   endtask : t_regs

   task automatic t_route();
      for (int c = 1; c < 4; c++)
      begin
         xfer(OFS_LOGIC_CTRL0, 1'b1, 16'(c));
         xfer(OFS_LOGIC_CTRL0 + 4'h1, 1'b1, 16'(c));
         logic_result_in <= 6'h03;
         repeat (6) @(posedge core_clk);
         check(high_side_pin, 4'h1 << c);
         check(low_side_pin, 4'h1 << c);
      end
      xfer(OFS_LOGIC_CTRL0 + 4'h1, 1'b1, 16'h0000);
      gen_low_in <= 4'h9;
      repeat (6) @(posedge core_clk);
      check(low_side_pin, 32'h9);
      logic_result_in <= 6'h00;
      gen_low_in <= 4'h0;
      $display("routing test done");
   endtask : t_route

   // Pulses one source and counts active cycles of event A
   task automatic ev_run(input logic [15:0] ctrl, input logic [3:0] k, input logic [2:0] g,
                         input logic [7:0] w);
      xfer(OFS_EVENT_CTRL0, 1'b1, ctrl);
      repeat (12) @(posedge core_clk);
      check(event_internal[0], ctrl[14]);
      check(event_pin_oe[0], ctrl[15]);
      check(event_output_pin[0], ctrl[14]);
      go <= 1'b1;
      kind <= k;
      gen <= g;
      width <= w;
      @(posedge core_clk);
      go <= 1'b0;
      cnt = 0;
      repeat (40)
      begin
         @(posedge core_clk);
         if (event_internal[0] !== ctrl[14])
            cnt++;
      end
      $display("event test done");
   endtask : ev_run

   // Mode inputs low: steering and half-period must give no event
   task automatic t_modes();
      mode_off <= 1'b1;
      ev_run(16'h2061, SEL_HALF, 3'h1, 8'h03);
      check(cnt, 0);
      ev_run(16'h2071, SEL_OUTPUT_STEERING_SIGNAL, 3'h1, 8'h03);
      check(cnt, 0);
      mode_off <= 1'b0;
      $display("mode gating test done");
   endtask : t_modes

   // A read is taken one edge after the write's last edge: one shift between
   task automatic t_prng();
      xfer(OFS_PRNG, 1'b0, 16'h0000);
      rd2 = rd;
      xfer(OFS_PRNG, 1'b0, 16'h0000);
      check(rd[15], 1'b0);
      check(rd != rd2 && rd2 != 32'h0, 1'b1);
      xfer(OFS_PRNG, 1'b1, 16'h0000);
      xfer(OFS_PRNG, 1'b0, 16'h0000);
      check(rd, 32'h1);
      xfer(OFS_PRNG, 1'b1, 16'hFFFF);
      xfer(OFS_PRNG, 1'b0, 16'h0000);
      check(rd, 32'h7FFE);
      $display("pseudorandom test done");
   endtask : t_prng

   initial
   begin
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      t_regs();
      t_route();
      for (int k = 0; k < 10; k++)
      begin
         ev_run({8'h20, 4'(k), 4'h1}, 4'(k), 3'h1, 8'h03);
         check(cnt, 3);
      end
      ev_run(16'h0010, SEL_GEN_OUT, 3'h0, 8'h01);
      check(cnt >= 8, 1'b1);
      ev_run(16'h3010, SEL_GEN_OUT, 3'h0, 8'h05);
      check(cnt, 2);
      ev_run(16'hE050, SEL_PCI_FAULT, 3'h0, 8'h03);
      check(cnt, 3);
      ev_run(16'h2013, SEL_GEN_OUT, 3'h3, 8'h03);
      check(cnt, 3);
      ev_run(16'h2014, SEL_GEN_OUT, 3'h0, 8'h03);
      check(cnt, 0);
      t_modes();
      t_prng();
      report_and_stop();
   end

   // Whole run is near 1060 cycles
   initial
   begin
      #200000;
      failures++;
      report_and_stop();
   end

endmodule : pel_event_logic_tb

/* sim/pel_gen_model.sv */
// Far-side model: generators, protection inputs and ADC triggers.
// Assumes the bench strobes go for one clock with kind, gen and width.
`timescale 1ns/1ps

module pel_gen_model
   import pel_pkg::*;
(
   // Clock, reset and command
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic [3:0] kind,
   input wire logic [2:0] gen,
   input wire logic [7:0] width,
   input wire logic mode_off,
   // Generator-side signals
   output logic [3:0] gen_trigger_in,
   output logic [3:0] gen_raw_out_in,
   output logic [3:0] pci_sync_in,
   output logic [3:0] pci_feedfwd_in,
   output logic [3:0] pci_curlim_in,
   output logic [3:0] pci_fault_in,
   output logic [3:0] half_period_signal,
   output logic [3:0] output_steering_signal,
   output logic [3:0] adc_trig1_in,
   output logic [3:0] adc_trig2_in,
   output logic [3:0] center_mode_in,
   output logic [3:0] push_pull_mode_in
);
   logic [7:0] left_ff;
   logic [3:0] kind_ff;
   logic [3:0] act_ff;
   logic [3:0] on;

   // Generator 5 and up does not exist, so its bit shifts out
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         left_ff <= 8'h00;
         kind_ff <= 4'h0;
         act_ff <= 4'h0;
      end
      else if (go)
      begin
         left_ff <= width;
         kind_ff <= kind;
         act_ff <= 4'h1 << gen;
      end
      else if (left_ff != 8'h00)
         left_ff <= left_ff - 8'h01;
   end

   assign on = (left_ff != 8'h00) ? act_ff : 4'h0;
   assign gen_trigger_in = (kind_ff == SEL_GEN_TRIG) ? on : 4'h0;
   assign gen_raw_out_in = (kind_ff == SEL_GEN_OUT) ? on : 4'h0;
   assign pci_sync_in = (kind_ff == SEL_PCI_SYNC) ? on : 4'h0;
   assign pci_feedfwd_in = (kind_ff == SEL_PCI_FF) ? on : 4'h0;
   assign pci_curlim_in = (kind_ff == SEL_PCI_CL) ? on : 4'h0;
   assign pci_fault_in = (kind_ff == SEL_PCI_FAULT) ? on : 4'h0;
   assign half_period_signal = (kind_ff == SEL_HALF) ? on : 4'h0;
   assign output_steering_signal = (kind_ff == SEL_OUTPUT_STEERING_SIGNAL) ? on : 4'h0;
   assign adc_trig1_in = (kind_ff == SEL_ADC1) ? on : 4'h0;
   assign adc_trig2_in = (kind_ff == SEL_ADC2) ? on : 4'h0;
   assign center_mode_in = mode_off ? 4'h0 : 4'hF;
   assign push_pull_mode_in = mode_off ? 4'h0 : 4'hF;

endmodule : pel_gen_model
